// File: src/tao_alarm_outputs.sv
`timescale 1ns/100ps
module tao_alarm_outputs (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic convDone,
    input wire tao_pkg::tao_temp_t localTemp,
    input wire tao_pkg::tao_temp_t remoteTemp,
    input wire logic remoteOpen,
    input wire logic araRequest,
    input wire logic araWon,
    input wire logic araLost,
    output logic araAck,
    output logic araAddrLsb,
    input wire logic criticalAlarmIn,
    output logic criticalAlarmOut,
    output logic criticalAlarmOe,
    input wire logic warnAlarmIn,
    output logic warnAlarmOut,
    output logic warnAlarmOe,
    output logic irq
);
    // Local copy keeps the many interrupt-width slices below short
    localparam int IRQ_NUM = tao_pkg::IRQ_NUM;

    tao_pkg::tao_state_t st;
    tao_pkg::tao_state_t next_st;

    // Bus request qualifiers
    logic access;
    logic wrLow;
    logic [7:0] limOfs;
    logic [2:0] limIdx;
    logic limHit;
    // Conversion evaluation
    tao_pkg::tao_temp_t effRemote;
    logic lHighV;
    logic lLowV;
    logic rHighV;
    logic rLowV;
    logic [2:0] nextLcnt;
    logic [2:0] nextRcnt;
    logic [2:0] needCnt;
    logic filtHit;
    logic persist;
    logic [IRQ_NUM-1:0] events;
    logic [IRQ_NUM-1:0] clearMask;
    logic [7:0] statusSet;

    // Hysteresis band: trips at or above hi, or below lo when the low side is used;
    // releases only when back inside the band shrunk by hyst on each used side
    function automatic logic band_next(input logic cur, input logic [7:0] t, input logic [7:0] hi,
                                       input logic [7:0] lo, input logic useLow, input logic [7:0] hyst);
        logic trip;
        logic inBand;
        trip = (t >= hi) || (useLow && (t < lo));
        inBand = ({1'b0, t} + {1'b0, hyst} <= {1'b0, hi})
               && (!useLow || ({1'b0, t} >= {1'b0, lo} + {1'b0, hyst}));
        band_next = trip || (cur && !inBand);
    endfunction

    // Register decode; writes take their data from the low byte lane only
    always_comb begin
        access = wb_cyc_i && wb_stb_i && !st.wbAck;
        wrLow = access && wb_we_i && wb_sel_i[0];
        limOfs = wb_adr_i - tao_pkg::OFS_LIM_FIRST;
        limIdx = limOfs[4:2];
        limHit = (wb_adr_i >= tao_pkg::OFS_LIM_FIRST) && (wb_adr_i <= tao_pkg::OFS_LIM_LAST)
               && (wb_adr_i[1:0] == 2'h0);
    end

    // Conversion result evaluation
    always_comb begin
        effRemote = remoteOpen ? st.remoteT : remoteTemp; // Last valid result kept
        lHighV = localTemp >= st.lim[tao_pkg::LIM_LHIGH];
        lLowV = localTemp < st.lim[tao_pkg::LIM_LLOW];
        rHighV = effRemote >= st.lim[tao_pkg::LIM_RHIGH];
        rLowV = effRemote < st.lim[tao_pkg::LIM_RLOW];
        // Counters saturate so a long run cannot wrap back below the threshold
        nextLcnt = !(lHighV || lLowV) ? 3'h0 : (st.lcnt == tao_pkg::CNT_MAX) ? st.lcnt : st.lcnt + 3'h1;
        nextRcnt = !(rHighV || rLowV) ? 3'h0 : (st.rcnt == tao_pkg::CNT_MAX) ? st.rcnt : st.rcnt + 3'h1;
        needCnt = {1'b0, st.consec} + 3'h1;
        filtHit = (nextLcnt >= needCnt) || (nextRcnt >= needCnt);
        persist = (st.lcnt >= needCnt) || (st.rcnt >= needCnt) || remoteOpen;
        statusSet = 8'h00;
        if (convDone) begin
            statusSet[tao_pkg::ST_LHIGH] = lHighV;
            statusSet[tao_pkg::ST_LLOW] = lLowV;
            statusSet[tao_pkg::ST_RHIGH] = rHighV;
            statusSet[tao_pkg::ST_RLOW] = rLowV;
            statusSet[tao_pkg::ST_OPEN] = remoteOpen;
            statusSet[tao_pkg::ST_LCRIT] = localTemp >= st.lim[tao_pkg::LIM_LCRIT];
            statusSet[tao_pkg::ST_RCRIT] = effRemote >= st.lim[tao_pkg::LIM_RCRIT];
        end
    end

    // Next state
    always_comb begin
        next_st = st;
        clearMask = '0;
        // Bus writes
        if (wrLow) begin
            if (wb_adr_i == tao_pkg::OFS_CONFIG) begin
                next_st.cfgMask = wb_dat_i[tao_pkg::CFG_MASK_BIT];
                next_st.cfgSelect = wb_dat_i[tao_pkg::CFG_SELECT_BIT];
            end
            if (wb_adr_i == tao_pkg::OFS_CONSEC) begin
                next_st.consec = wb_dat_i[1:0];
            end
            if (wb_adr_i == tao_pkg::OFS_HYST) begin
                next_st.hyst = wb_dat_i[7:0];
            end
            if (limHit) begin
                next_st.lim[limIdx] = wb_dat_i[7:0];
            end
            if (wb_adr_i == tao_pkg::OFS_INT_CLEAR) begin
                clearMask = wb_dat_i[IRQ_NUM-1:0];
            end
            if (wb_adr_i == tao_pkg::OFS_INT_ENABLE) begin
                next_st.intEnable = wb_dat_i[IRQ_NUM-1:0];
            end
        end
        // Status clears on read; a flag set in the same cycle survives
        if (access && !wb_we_i && (wb_adr_i == tao_pkg::OFS_STATUS)) begin
            next_st.status = 8'h00;
        end
        next_st.status = next_st.status | statusSet;
        // New conversion result
        if (convDone) begin
            next_st.localT = localTemp;
            next_st.remoteT = effRemote;
            next_st.lcnt = nextLcnt;
            next_st.rcnt = nextRcnt;
            // Critical compares use the critical limits only, never the config bits
            next_st.critL = band_next(st.critL, localTemp, st.lim[tao_pkg::LIM_LCRIT], 8'h00, 1'b0, st.hyst);
            next_st.critR = band_next(st.critR, effRemote, st.lim[tao_pkg::LIM_RCRIT], 8'h00, 1'b0, st.hyst);
            // Second critical bands track the high/low limits
            next_st.crit2L = band_next(st.crit2L, localTemp, st.lim[tao_pkg::LIM_LHIGH],
                                       st.lim[tao_pkg::LIM_LLOW], 1'b1, st.hyst);
            next_st.crit2R = band_next(st.crit2R, effRemote, st.lim[tao_pkg::LIM_RHIGH],
                                       st.lim[tao_pkg::LIM_RLOW], 1'b1, st.hyst);
            // Early warning latches only in alert mode and while unmasked
            if (!st.cfgMask && !st.cfgSelect && !st.alertOn && (filtHit || remoteOpen)) begin
                next_st.alertOn = 1'b1;
                next_st.alertHigh = (lHighV && (nextLcnt >= needCnt)) || (rHighV && (nextRcnt >= needCnt));
            end
        end
        // Alert response: answer with the cause bit
        next_st.araAck = 1'b0;
        if (araRequest && st.alertOn) begin
            next_st.araAck = 1'b1;
            next_st.araLsb = st.alertHigh;
        end
        // Won arbitration releases only with cause gone and status read
        if (araWon && st.alertOn && !persist && !convDone && (st.status == 8'h00)) begin
            next_st.alertOn = 1'b0;
        end
        // Sticky interrupt flags; set wins over clear
        events[tao_pkg::IRQ_CRIT] = (next_st.critL || next_st.critR) && !(st.critL || st.critR);
        events[tao_pkg::IRQ_WARN] = next_st.alertOn && !st.alertOn;
        events[tao_pkg::IRQ_OPEN] = convDone && remoteOpen;
        next_st.intStatus = (st.intStatus & ~clearMask) | events;
        next_st.irq = |(next_st.intStatus & next_st.intEnable);
        // Open-drain enables: active means the pin is pulled low
        next_st.critOe = next_st.critL || next_st.critR;
        next_st.warnOe = !next_st.cfgMask && (next_st.cfgSelect ? (next_st.crit2L || next_st.crit2R)
                                                               : next_st.alertOn);
        // Bus answer one cycle after the request; unmapped reads return zero
        next_st.wbAck = access;
        next_st.wbDat = 32'h0000_0000;
        if (access && !wb_we_i) begin
            if (wb_adr_i == tao_pkg::OFS_CONFIG) begin
                next_st.wbDat[tao_pkg::CFG_MASK_BIT] = st.cfgMask;
                next_st.wbDat[tao_pkg::CFG_SELECT_BIT] = st.cfgSelect;
            end
            if (wb_adr_i == tao_pkg::OFS_CONSEC) begin
                next_st.wbDat[1:0] = st.consec;
            end
            if (wb_adr_i == tao_pkg::OFS_HYST) begin
                next_st.wbDat[7:0] = st.hyst;
            end
            if (limHit) begin
                next_st.wbDat[7:0] = st.lim[limIdx];
            end
            if (wb_adr_i == tao_pkg::OFS_STATUS) begin
                next_st.wbDat[7:0] = st.status;
            end
            if (wb_adr_i == tao_pkg::OFS_INT_STATUS) begin
                next_st.wbDat[IRQ_NUM-1:0] = st.intStatus;
            end
            if (wb_adr_i == tao_pkg::OFS_INT_ENABLE) begin
                next_st.wbDat[IRQ_NUM-1:0] = st.intEnable;
            end
            if (wb_adr_i == tao_pkg::OFS_TEMPS) begin
                next_st.wbDat = {6'h00, warnAlarmIn, criticalAlarmIn, 8'h00, st.remoteT, st.localT};
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.hyst <= tao_pkg::HYST_RESET;
            st.consec <= tao_pkg::CONSEC_RESET;
            st.lim[tao_pkg::LIM_LHIGH] <= tao_pkg::HIGH_RESET;
            st.lim[tao_pkg::LIM_LLOW] <= tao_pkg::LOW_RESET;
            st.lim[tao_pkg::LIM_LCRIT] <= tao_pkg::CRIT_RESET;
            st.lim[tao_pkg::LIM_RHIGH] <= tao_pkg::HIGH_RESET;
            st.lim[tao_pkg::LIM_RLOW] <= tao_pkg::LOW_RESET;
            st.lim[tao_pkg::LIM_RCRIT] <= tao_pkg::CRIT_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops; pin data is a constant low
    assign wb_dat_o = st.wbDat;
    assign wb_ack_o = st.wbAck;
    assign araAck = st.araAck;
    assign araAddrLsb = st.araLsb;
    assign criticalAlarmOut = 1'b0;
    assign criticalAlarmOe = st.critOe;
    assign warnAlarmOut = 1'b0;
    assign warnAlarmOe = st.warnOe;
    assign irq = st.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_pins_low_only: assert property (!criticalAlarmOut && !warnAlarmOut)
        else $error("Alarm pin driven high");
    a_crit_trips: assert property (convDone && (localTemp >= st.lim[tao_pkg::LIM_LCRIT]) |=> criticalAlarmOe)
        else $error("Critical alarm missed a local trip");
    a_crit_unmasked: assert property ((st.critL || st.critR) && st.cfgMask |-> criticalAlarmOe)
        else $error("Critical alarm suppressed by configuration");
    a_crit_release: assert property (st.critL && convDone && !remoteOpen && !st.critR
        && ({1'b0, localTemp} + {1'b0, st.hyst} <= {1'b0, st.lim[tao_pkg::LIM_LCRIT]})
        && ({1'b0, effRemote} + {1'b0, st.hyst} <= {1'b0, st.lim[tao_pkg::LIM_RCRIT]})
        |=> !criticalAlarmOe)
        else $error("Critical alarm failed to release");
    a_hyst_reset: assert property (@(posedge clk_sys) reset_n && !$past(reset_n) |-> st.hyst == 8'h0a)
        else $error("Hysteresis reset value wrong");
    a_mask_release: assert property (st.cfgMask |-> !warnAlarmOe)
        else $error("Masked warning pin driven");
    a_warn_filter: assert property ($rose(st.alertOn) |-> st.status[tao_pkg::ST_OPEN]
        || (st.lcnt >= needCnt) || (st.rcnt >= needCnt))
        else $error("Warning asserted before enough violations");
    a_counter_clear: assert property (convDone && !lHighV && !lLowV |=> st.lcnt == 3'h0)
        else $error("Violation counter not cleared");
    a_ara_answer: assert property (araRequest && st.alertOn |=> araAck && (araAddrLsb == $past(st.alertHigh)))
        else $error("Alert response not answered");
    a_lost_keeps: assert property (araLost && !araWon && st.alertOn |=> st.alertOn)
        else $error("Warning released after lost arbitration");
    a_open_keeps: assert property (convDone && remoteOpen |=> st.remoteT == $past(st.remoteT)
        && st.status[tao_pkg::ST_OPEN])
        else $error("Open diode handling wrong");

    // Pin two by mode; a config write in the same cycle is left out, as it retargets the pin
    a_second_trip: assert property (convDone && !wrLow && st.cfgSelect && !st.cfgMask
        && (localTemp < st.lim[tao_pkg::LIM_LLOW]) |=> warnAlarmOe)
        else $error("Second critical missed a low trip");
    a_warn_sets: assert property (convDone && !wrLow && !st.cfgMask && !st.cfgSelect
        && (nextLcnt >= needCnt) |=> warnAlarmOe)
        else $error("Warning missed a local violation run");
    a_open_warns: assert property (convDone && remoteOpen && !wrLow && !st.cfgMask && !st.cfgSelect
        |=> warnAlarmOe)
        else $error("Warning missed an open diode");
    a_mask_no_latch: assert property (st.cfgMask && !st.alertOn |=> !st.alertOn)
        else $error("Warning latched while masked");
    // Release path: only a won response after the status was read clear drops the latch
    a_status_holds: assert property (st.alertOn && (st.status != 8'h00) |=> st.alertOn)
        else $error("Warning released with status still set");
    a_ara_silent: assert property (araRequest && !st.alertOn |=> !araAck)
        else $error("Alert response answered without an alert");
    // Remote critical trip, and local critical hold while still inside the hysteresis band
    a_crit_remote: assert property (convDone && (effRemote >= st.lim[tao_pkg::LIM_RCRIT])
        |=> criticalAlarmOe)
        else $error("Critical alarm missed a remote trip");
    a_crit_hold: assert property (st.critL && convDone
        && ({1'b0, localTemp} + {1'b0, st.hyst} > {1'b0, st.lim[tao_pkg::LIM_LCRIT]}) |=> criticalAlarmOe)
        else $error("Critical alarm released inside hysteresis");
    a_remote_clear: assert property (convDone && !rHighV && !rLowV |=> st.rcnt == 3'h0)
        else $error("Remote violation counter not cleared");
endmodule // tao_alarm_outputs

// File: inc/tao_pkg.sv
package tao_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_CONSEC = 8'h04;
    localparam logic [7:0] OFS_HYST = 8'h08;
    localparam logic [7:0] OFS_LIM_FIRST = 8'h0c;
    localparam logic [7:0] OFS_LIM_LAST = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_INT_STATUS = 8'h28;
    localparam logic [7:0] OFS_INT_CLEAR = 8'h2c;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h30;
    localparam logic [7:0] OFS_TEMPS = 8'h34;

    // Limit table entries, one word each from OFS_LIM_FIRST upward
    localparam int LIM_NUM = 6;
    localparam int LIM_LHIGH = 0;
    localparam int LIM_LLOW = 1;
    localparam int LIM_LCRIT = 2;
    localparam int LIM_RHIGH = 3;
    localparam int LIM_RLOW = 4;
    localparam int LIM_RCRIT = 5;

    // Field positions
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_SELECT_BIT = 5;
    localparam int ST_LHIGH = 6;
    localparam int ST_LLOW = 5;
    localparam int ST_RHIGH = 4;
    localparam int ST_RLOW = 3;
    localparam int ST_OPEN = 2;
    localparam int ST_RCRIT = 1;
    localparam int ST_LCRIT = 0;
    localparam int IRQ_CRIT = 0;
    localparam int IRQ_WARN = 1;
    localparam int IRQ_OPEN = 2;
    localparam int IRQ_NUM = 3;

    // Reset values
    localparam logic [7:0] HYST_RESET = 8'h0a;
    localparam logic [7:0] HIGH_RESET = 8'h50;
    localparam logic [7:0] LOW_RESET = 8'h00;
    localparam logic [7:0] CRIT_RESET = 8'h5a;
    localparam logic [1:0] CONSEC_RESET = 2'h0;
    localparam logic [2:0] CNT_MAX = 3'h4;

    typedef logic [7:0] tao_temp_t;

    // Whole state of the alarm block
    typedef struct packed {
        logic cfgMask;
        logic cfgSelect;
        logic [1:0] consec;
        tao_temp_t hyst;
        tao_temp_t [LIM_NUM-1:0] lim;
        tao_temp_t localT;
        tao_temp_t remoteT;
        logic [7:0] status;
        logic [2:0] lcnt;
        logic [2:0] rcnt;
        logic critL;
        logic critR;
        logic crit2L;
        logic crit2R;
        logic alertOn;
        logic alertHigh;
        logic [IRQ_NUM-1:0] intStatus;
        logic [IRQ_NUM-1:0] intEnable;
        logic critOe;
        logic warnOe;
        logic araAck;
        logic araLsb;
        logic irq;
        logic wbAck;
        logic [31:0] wbDat;
    } tao_state_t;
endpackage

// File: verif/tao_host_model.sv
`timescale 1ns/100ps
// Host end of both alarm wires, with the pull-ups and the alert-response sequencer
module tao_host_model (
    input wire logic clk_sys,
    input wire logic criticalAlarmOe,
    input wire logic warnAlarmOe,
    input wire logic otherPull,
    input wire logic araAck,
    input wire logic araAddrLsb,
    output logic criticalWire,
    output logic warnWire,
    output logic araRequest,
    output logic araWon,
    output logic araLost
);
    // Pull-ups: a shared wire reads low while any sensor sinks it
    assign criticalWire = ~(criticalAlarmOe | otherPull);
    assign warnWire = ~(warnAlarmOe | otherPull);

    // Idle host issues no alert response
    initial begin
        araRequest = 1'b0;
        araWon = 1'b0;
        araLost = 1'b0;
    end

    // Request, collect the returned address bit, then close arbitration won or lost
    task automatic alert_response(input logic lose, output logic acked, output logic lsb);
        acked = 1'b0;
        lsb = 1'b0;
        @(posedge clk_sys);
        araRequest <= 1'b1;
        @(posedge clk_sys);
        araRequest <= 1'b0;
        // A device without a pending alert stays silent, so the window is bounded
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            if (araAck === 1'b1) begin
                acked = 1'b1;
                lsb = araAddrLsb;
            end
        end
        araWon <= ~lose;
        araLost <= lose;
        @(posedge clk_sys);
        araWon <= 1'b0;
        araLost <= 1'b0;
    endtask
endmodule // tao_host_model

// File: verif/temperature_alarm_outputs_tb.sv
`timescale 1ns/100ps
module temperature_alarm_outputs_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0, wbDatR, rd;
    logic wbAck, convDone = 1'b0, remoteOpen = 1'b0, otherPull = 1'b0;
    tao_pkg::tao_temp_t localTemp = 8'h00, remoteTemp = 8'h00;
    logic araRequest, araWon, araLost, araAck, araAddrLsb, acked, lsb;
    logic criticalWire, warnWire, critOut, critOe, warnOut, warnOe, irq;
    logic [7:0] secTemp [6] = '{8'h50, 8'h47, 8'h46, 8'h05, 8'h19, 8'h1a};
    logic secExp [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    int badCount = 0, numChecks = 0;

    always #2 clk_sys = ~clk_sys;

    tao_alarm_outputs dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .convDone(convDone), .localTemp(localTemp), .remoteTemp(remoteTemp),
        .remoteOpen(remoteOpen), .araRequest(araRequest), .araWon(araWon), .araLost(araLost),
        .araAck(araAck), .araAddrLsb(araAddrLsb), .criticalAlarmIn(criticalWire), .criticalAlarmOut(critOut),
        .criticalAlarmOe(critOe), .warnAlarmIn(warnWire), .warnAlarmOut(warnOut), .warnAlarmOe(warnOe), .irq(irq));

    tao_host_model host_u (.clk_sys(clk_sys), .criticalAlarmOe(critOe), .warnAlarmOe(warnOe),
        .otherPull(otherPull), .araAck(araAck), .araAddrLsb(araAddrLsb), .criticalWire(criticalWire),
        .warnWire(warnWire), .araRequest(araRequest), .araWon(araWon), .araLost(araLost));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Classic single cycle; a missing ack ends the run instead of hanging it
    task automatic wbAccess(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
        int n;
        n = 0;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= wdat;
        wbSel <= 4'h1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 16);
        if (wbAck !== 1'b1) begin
            badCount++;
            printVerdict();
        end
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        wbAccess(1'b1, adr, d);
    endtask

    task automatic rdChk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        wbAccess(1'b0, adr, 32'h0);
        check(what, rd, exp);
    endtask

    // One conversion result, then one edge so the registered pins show it
    task automatic conv(input logic [7:0] lt, input logic [7:0] rt, input logic open);
        @(posedge clk_sys);
        convDone <= 1'b1;
        localTemp <= lt;
        remoteTemp <= rt;
        remoteOpen <= open;
        @(posedge clk_sys);
        convDone <= 1'b0;
        remoteOpen <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic ara(input logic lose);
        host_u.alert_response(lose, acked, lsb);
        @(posedge clk_sys);
    endtask

    // Watchdog against a stuck sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        badCount++;
        printVerdict();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        rdChk("config", tao_pkg::OFS_CONFIG, 32'h0);
        rdChk("hyst", tao_pkg::OFS_HYST, 32'h0a);
        rdChk("unmapped", 8'h40, 32'h0);
        check("reset pins", {critOe, warnOe, araAck, irq}, 4'h0);
        $display("test reset done");
        // Critical alarm must ignore the mask bit; interrupt follows it
        wr(tao_pkg::OFS_INT_ENABLE, 32'h1);
        wr(tao_pkg::OFS_CONFIG, 32'h80);
        conv(8'h5a, 8'h20, 1'b0);
        check("crit oe", critOe, 1'b1);
        check("crit wire", {critOut, criticalWire}, 2'b00);
        check("warn masked", warnOe, 1'b0);
        check("irq", irq, 1'b1);
        conv(8'h51, 8'h20, 1'b0);
        check("crit hyst hold", critOe, 1'b1);
        conv(8'h50, 8'h20, 1'b0);
        check("crit release", {critOe, criticalWire}, 2'b01);
        // Another sensor sinking the shared wires must win over our released pins
        otherPull <= 1'b1;
        @(posedge clk_sys);
        check("wire-or", {critOe, criticalWire, warnWire}, 3'b000);
        otherPull <= 1'b0;
        conv(8'h20, 8'h5a, 1'b0);
        check("remote crit", critOe, 1'b1);
        conv(8'h20, 8'h20, 1'b0);
        wr(tao_pkg::OFS_INT_ENABLE, 32'h0);
        check("irq masked", irq, 1'b0);
        wr(tao_pkg::OFS_INT_CLEAR, 32'h7);
        wr(tao_pkg::OFS_INT_ENABLE, 32'h1);
        rdChk("int status", tao_pkg::OFS_INT_STATUS, 32'h0);
        wbAccess(1'b0, tao_pkg::OFS_STATUS, 32'h0);
        $display("test critical done");
        // Every consecutive count, a broken run, and the release conditions
        wr(tao_pkg::OFS_CONFIG, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(tao_pkg::OFS_CONSEC, k);
            if (k > 0) begin
                conv(8'h55, 8'h20, 1'b0);
                conv(8'h20, 8'h20, 1'b0);
            end
            repeat (k) conv(8'h55, 8'h20, 1'b0);
            check("warn early", warnOe, 1'b0);
            conv(8'h55, 8'h20, 1'b0);
            check("warn on", {warnOut, warnOe, warnWire}, 3'b010);
            ara(1'b0);
            check("ara high", {acked, lsb, warnOe}, 3'b111);
            conv(8'h20, 8'h20, 1'b0);
            ara(1'b0);
            check("status unread", warnOe, 1'b1);
            wbAccess(1'b0, tao_pkg::OFS_STATUS, 32'h0);
            ara(1'b0);
            check("warn released", warnOe, 1'b0);
        end
        ara(1'b0);
        check("no alert no ack", acked, 1'b0);
        $display("test consecutive done");
        // Low-limit cause and lost arbitration
        wr(tao_pkg::OFS_CONSEC, 32'h0);
        wr(8'h10, 32'h10);
        conv(8'h05, 8'h20, 1'b0);
        conv(8'h20, 8'h20, 1'b0);
        wbAccess(1'b0, tao_pkg::OFS_STATUS, 32'h0);
        ara(1'b1);
        check("ara low lost", {acked, lsb, warnOe}, 3'b101);
        ara(1'b0);
        check("won release", warnOe, 1'b0);
        $display("test arbitration done");
        // Open diode keeps the last remote result
        conv(8'h20, 8'h33, 1'b1);
        check("open warn", warnOe, 1'b1);
        rdChk("temps", tao_pkg::OFS_TEMPS, 32'h0100_2020);
        rdChk("status open", tao_pkg::OFS_STATUS, 32'h04);
        conv(8'h20, 8'h20, 1'b0);
        ara(1'b0);
        wr(tao_pkg::OFS_CONFIG, 32'h80);
        conv(8'h20, 8'h20, 1'b1);
        check("open masked", warnOe, 1'b0);
        conv(8'h20, 8'h20, 1'b0);
        wbAccess(1'b0, tao_pkg::OFS_STATUS, 32'h0);
        $display("test open done");
        // Second critical: high and low limits with hysteresis
        wr(tao_pkg::OFS_CONFIG, 32'h20);
        for (int i = 0; i < 6; i++) begin
            conv(secTemp[i], 8'h20, 1'b0);
            check("second crit", {warnOe, critOe}, {secExp[i], 1'b0});
        end
        $display("test second critical done");
        printVerdict();
    end
endmodule // temperature_alarm_outputs_tb
